// ### hdl/efic_core.sv
// event flag latches, routing and wishbone register slave
`timescale 1ns/100ps
`include "efic_regs.svh"
module efic_core #(
    parameter int NUM_FLAGS = 10
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_stb_i,
    input wire logic wb_cyc_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic [NUM_FLAGS-1:0] event_source_i,
    output logic [NUM_FLAGS-1:0] source_clear_o,
    input wire logic request_out_a_n_i,
    output logic request_out_a_n_o,
    output logic request_out_a_n_oe_o,
    input wire logic request_out_b_n_i,
    output logic request_out_b_n_o,
    output logic request_out_b_n_oe_o,
    output logic irq_o
);
    // ==========================================
    // bus decode
    efic_pkg::efic_wb_req_t req;
    logic hit;
    logic mapped;
    logic wr;
    logic rd;
    logic lane0;
    assign req = '{adr: wb_adr_i, dat: wb_dat_i, sel: wb_sel_i, we: wb_we_i,
                   stb: wb_stb_i, cyc: wb_cyc_i};
    // one-cycle answer, ack dropped the cycle after it was given
    assign hit = req.cyc && req.stb && !wb_ack_o && !wb_err_o;
    always_comb begin
        unique case (req.adr)
            `EFIC_ADDR_ENABLE_LOW, `EFIC_ADDR_ENABLE_HIGH, `EFIC_ADDR_FLAGS_LOW,
            `EFIC_ADDR_FLAGS_HIGH, `EFIC_ADDR_ROUTE_LOW, `EFIC_ADDR_ROUTE_HIGH,
            `EFIC_ADDR_SOFT_RESET, `EFIC_ADDR_STATUS, `EFIC_ADDR_MASK: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign wr = hit && mapped && req.we;
    assign rd = hit && mapped && !req.we;
    // only the low byte lane carries data; other lanes are ignored
    assign lane0 = req.sel[0];

    // ==========================================
    // control registers
    logic [NUM_FLAGS-1:0] enable_reg;
    logic [NUM_FLAGS-1:0] route_reg;
    logic [1:0] mask_reg;
    logic soft_reset;
    logic [NUM_FLAGS-1:0] wdat_wide;
    assign wdat_wide = {req.dat[`EFIC_HIGH_BITS-1:0], req.dat[`EFIC_LOW_BITS-1:0]};
    assign soft_reset = wr && lane0 && (req.adr == `EFIC_ADDR_SOFT_RESET)
                        && req.dat[`EFIC_SOFT_RESET_BIT];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_reg <= `EFIC_RESET_ENABLE;
            route_reg <= `EFIC_RESET_ROUTE;
            mask_reg <= `EFIC_RESET_MASK;
        end else if (wr && lane0) begin
            unique case (req.adr)
                `EFIC_ADDR_ENABLE_LOW: enable_reg[`EFIC_LOW_BITS-1:0] <= req.dat[7:0];
                `EFIC_ADDR_ENABLE_HIGH: enable_reg[NUM_FLAGS-1:`EFIC_LOW_BITS] <=
                    wdat_wide[NUM_FLAGS-1:`EFIC_LOW_BITS];
                `EFIC_ADDR_ROUTE_LOW: route_reg[`EFIC_LOW_BITS-1:0] <= req.dat[7:0];
                `EFIC_ADDR_ROUTE_HIGH: route_reg[NUM_FLAGS-1:`EFIC_LOW_BITS] <=
                    wdat_wide[NUM_FLAGS-1:`EFIC_LOW_BITS];
                `EFIC_ADDR_MASK: mask_reg <= req.dat[1:0];
                default: ;
            endcase
        end
    end

    // ==========================================
    // flag latches
    logic [NUM_FLAGS-1:0] src_prev_reg;
    logic [NUM_FLAGS-1:0] latch_reg;
    logic [NUM_FLAGS-1:0] w1c;
    logic [NUM_FLAGS-1:0] rise;
    always_comb begin
        w1c = '0;
        if (wr && lane0 && req.adr == `EFIC_ADDR_FLAGS_LOW)
            w1c[`EFIC_LOW_BITS-1:0] = req.dat[7:0];
        if (wr && lane0 && req.adr == `EFIC_ADDR_FLAGS_HIGH)
            w1c[NUM_FLAGS-1:`EFIC_LOW_BITS] = wdat_wide[NUM_FLAGS-1:`EFIC_LOW_BITS];
    end
    assign rise = event_source_i & ~src_prev_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i)
            src_prev_reg <= '0;
        else
            src_prev_reg <= event_source_i;
    end

    genvar g;
    generate
        for (g = 0; g < NUM_FLAGS; g++) begin : g_flag
            always_ff @(posedge clk_i) begin
                if (rst_i || soft_reset) begin
                    latch_reg[g] <= 1'b0;
                end else if (enable_reg[g] && rise[g]) begin
                    latch_reg[g] <= 1'b1; // set wins over a same-cycle clear
                end else if (w1c[g]) begin
                    latch_reg[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // write to a flag bit also clears an internally latched source
    always_ff @(posedge clk_i) begin
        if (rst_i)
            source_clear_o <= '0;
        else
            source_clear_o <= w1c;
    end

    // ==========================================
    // request routing
    logic [NUM_FLAGS-1:0] active;
    logic req_a;
    logic req_b;
    assign active = latch_reg & enable_reg;
    assign req_a = |(active & ~route_reg);
    assign req_b = |(active & route_reg);
    // drive value is a constant low; only the enable moves
    assign request_out_a_n_o = 1'b0;
    assign request_out_b_n_o = 1'b0;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            request_out_a_n_oe_o <= 1'b1;
            request_out_b_n_oe_o <= 1'b1;
        end else begin
            request_out_a_n_oe_o <= !req_a;
            request_out_b_n_oe_o <= !req_b;
        end
    end

    // ==========================================
    // pin event status, cleared by reading
    logic [1:0] status_reg;
    logic [1:0] pin_rise;
    assign pin_rise = {req_b && request_out_b_n_oe_o, req_a && request_out_a_n_oe_o};
    always_ff @(posedge clk_i) begin
        if (rst_i)
            status_reg <= '0;
        else if (rd && req.adr == `EFIC_ADDR_STATUS)
            status_reg <= pin_rise;
        else
            status_reg <= status_reg | pin_rise;
    end
    assign irq_o = |(status_reg & mask_reg);

    // ==========================================
    // read data and ack
    logic [NUM_FLAGS-1:0] flag_view;
    logic [7:0] rdat;
    // disabled flags show the live source level
    assign flag_view = (latch_reg & enable_reg) | (event_source_i & ~enable_reg);
    always_comb begin
        unique case (req.adr)
            `EFIC_ADDR_ENABLE_LOW: rdat = enable_reg[7:0];
            `EFIC_ADDR_ENABLE_HIGH: rdat = {6'h00, enable_reg[NUM_FLAGS-1:8]};
            `EFIC_ADDR_FLAGS_LOW: rdat = flag_view[7:0];
            `EFIC_ADDR_FLAGS_HIGH: rdat = {6'h00, flag_view[NUM_FLAGS-1:8]};
            `EFIC_ADDR_ROUTE_LOW: rdat = route_reg[7:0];
            `EFIC_ADDR_ROUTE_HIGH: rdat = {6'h00, route_reg[NUM_FLAGS-1:8]};
            `EFIC_ADDR_STATUS: rdat = {6'h00, status_reg};
            `EFIC_ADDR_MASK: rdat = {6'h00, mask_reg};
            default: rdat = 8'h00;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= hit && mapped;
            wb_err_o <= hit && !mapped;
            wb_dat_o <= (hit && mapped && !req.we) ? {24'h00_0000, rdat} : 32'h0000_0000;
        end
    end

    // ==========================================
    // checks
    set_on_rise_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (enable_reg[0] && rise[0] && !soft_reset) |=> latch_reg[0])
        else $error("enabled rising edge did not latch flag");
    w1c_clears_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (w1c[0] && !rise[0] && !soft_reset) |=> !latch_reg[0])
        else $error("write one did not clear flag");
    soft_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
        soft_reset |=> latch_reg == '0)
        else $error("soft reset left a flag latched");
    route_a_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (active[0] && !route_reg[0]) |=> !request_out_a_n_oe_o)
        else $error("output a not asserted for routed flag");
    route_b_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (active[0] && route_reg[0]) |=> !request_out_b_n_oe_o)
        else $error("output b not asserted for routed flag");
    release_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (active == '0) |=> (request_out_a_n_oe_o && request_out_b_n_oe_o))
        else $error("request held with no active flag");
    never_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !request_out_a_n_o && !request_out_b_n_o)
        else $error("request pin driven high");
    disabled_live_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !enable_reg[0] |-> (flag_view[0] == event_source_i[0]))
        else $error("disabled flag does not show live source");
    src_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        w1c[1] |=> source_clear_o[1])
        else $error("source clear not pulsed");
    ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    ack_on_hit_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (hit && mapped) |=> (wb_ack_o && !wb_err_o))
        else $error("mapped access not acknowledged");
    err_unmapped_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (hit && !mapped) |=> (wb_err_o && !wb_ack_o))
        else $error("unmapped access not refused");
    set_high_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (enable_reg[NUM_FLAGS-1] && rise[NUM_FLAGS-1] && !soft_reset)
        |=> latch_reg[NUM_FLAGS-1])
        else $error("enabled rising edge did not latch top flag");
    disabled_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (enable_reg == '0) |=> (request_out_a_n_oe_o && request_out_b_n_oe_o))
        else $error("request asserted with every flag disabled");
    pin_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !request_out_a_n_oe_o |-> !request_out_a_n_i)
        else $error("request line not low while pulled");
    status_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        pin_rise[0] |=> status_reg[0])
        else $error("pin event not recorded in status");
    latch_cov_c: cover property (@(posedge clk_i) disable iff (rst_i)
        enable_reg[0] && rise[0] ##1 !request_out_a_n_oe_o);
    clear_cov_c: cover property (@(posedge clk_i) disable iff (rst_i)
        latch_reg[0] ##1 w1c[0] ##1 !latch_reg[0]);
    route_b_cov_c: cover property (@(posedge clk_i) disable iff (rst_i)
        !request_out_b_n_oe_o);
endmodule : efic_core

// ### hdl/efic_regs.svh
// register map, field layout and reset values of the event flag interrupt controller
// How it works
// - each request output is active low open drain: pulls low, never drives high
// - ten event flags live in two flag registers at consecutive addresses
// - every flag has its own enable bit in two enable registers
// - enabled flag sets and holds on rising edge of its source, not level
// - latched enabled flag asserts the request output it is routed to
// - disabled flag reads live source level and never asserts a request
// - writing 1 to a latched flag bit clears it; host prefers this
// - hardware or software reset clears every latched flag
// - both request outputs behave alike; any flag combination may drive one
// - one routing bit per flag: 0 selects output a, 1 selects output b
// - internally latched sources clear when host writes the matching flag bit
`ifndef EFIC_REGS_SVH
`define EFIC_REGS_SVH
`define EFIC_ADDR_ENABLE_LOW 4'h3
`define EFIC_ADDR_ENABLE_HIGH 4'h4
`define EFIC_ADDR_FLAGS_LOW 4'h5
`define EFIC_ADDR_FLAGS_HIGH 4'h6
`define EFIC_ADDR_ROUTE_LOW 4'h7
`define EFIC_ADDR_ROUTE_HIGH 4'h8
`define EFIC_ADDR_SOFT_RESET 4'h9
`define EFIC_ADDR_STATUS 4'hA
`define EFIC_ADDR_MASK 4'hB
`define EFIC_LOW_BITS 8
`define EFIC_HIGH_BITS 2
`define EFIC_RESET_ENABLE 10'h000
`define EFIC_RESET_ROUTE 10'h000
`define EFIC_RESET_MASK 2'h0
`define EFIC_SOFT_RESET_BIT 0
`endif

// ### hdl/efic_pkg.sv
// types shared by the event flag interrupt controller
package efic_pkg;
    typedef struct packed {
        logic [3:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
        logic we;
        logic stb;
        logic cyc;
    } efic_wb_req_t;
    typedef struct packed {
        logic pull;
        logic oe_n;
    } efic_od_pin_t;
endpackage : efic_pkg

// ### test/efic_host_line.sv
// pulled-up request lines as the host sees them, with one other open-drain device on line a
`timescale 1ns/100ps
// ==========================
// partner line model
module efic_host_line (
    input wire logic pull_a_i,
    input wire logic oe_a_n_i,
    input wire logic pull_b_i,
    input wire logic oe_b_n_i,
    input wire logic other_n_i,
    output logic line_a_o,
    output logic line_b_o
);
    // a driven high never lifts the line: only the pull-up does
    assign line_a_o = ((!oe_a_n_i && !pull_a_i) || !other_n_i) ? 1'b0 : 1'b1;
    assign line_b_o = (!oe_b_n_i && !pull_b_i) ? 1'b0 : 1'b1;
endmodule : efic_host_line

// ### test/efic_core_tb_top.sv
// self-checking bench of the event flag interrupt controller
`timescale 1ns/100ps
`include "efic_regs.svh"
module efic_core_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    efic_pkg::efic_wb_req_t req = '0;
    logic [9:0] src = 10'h000;
    logic other_n = 1'b1;
    logic [31:0] rdat;
    logic ack, err, irq, oe_a, oe_b, drv_a, drv_b, line_a, line_b;
    logic [9:0] clr;
    logic [9:0] clr_seen = 10'h000;
    logic [33:0] notes[$];
    logic [33:0] nt;
    logic [9:0] p, rt;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #12.5 clk = ~clk;
    // ==========================
    // design and host lines
    efic_core DUT (.clk_i(clk), .rst_i(rst), .wb_adr_i(req.adr), .wb_dat_i(req.dat),
        .wb_sel_i(req.sel), .wb_we_i(req.we), .wb_stb_i(req.stb), .wb_cyc_i(req.cyc),
        .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .event_source_i(src),
        .source_clear_o(clr), .request_out_a_n_i(line_a), .request_out_a_n_o(drv_a),
        .request_out_a_n_oe_o(oe_a), .request_out_b_n_i(line_b), .request_out_b_n_o(drv_b),
        .request_out_b_n_oe_o(oe_b), .irq_o(irq));
    efic_host_line host (.pull_a_i(drv_a), .oe_a_n_i(oe_a), .pull_b_i(drv_b), .oe_b_n_i(oe_b),
        .other_n_i(other_n), .line_a_o(line_a), .line_b_o(line_b));
    // ==========================
    // compares and bus cycles
    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk_word
    task automatic chk_bit(input string what, input logic exp, input logic seen);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
        end
    endtask : chk_bit
    // note: [33] read data checked, [32] error answer expected
    task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d,
                       input logic [33:0] note);
        notes.push_back(note);
        req <= '{adr: a, dat: {24'h0, d}, sel: 4'hF, we: w, stb: 1'b1, cyc: 1'b1};
        do @(posedge clk); while (ack !== 1'b1 && err !== 1'b1);
        req <= '0;
        @(posedge clk);
    endtask : bus
    task automatic rd(input logic [3:0] a, input logic [7:0] d);
        bus(a, 1'b0, 8'h00, {2'b10, 24'h0, d});
    endtask : rd
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(a, 1'b1, d, 34'h0);
    endtask : wr
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    // ==========================
    // answer monitor, clear pulse collector, hang guard
    always @(posedge clk) begin
        if (ack === 1'b1 || err === 1'b1) begin
            nt = notes.pop_front();
            chk_bit("bus_err", nt[32], err);
            if (nt[33])
                chk_word("read_data", nt[31:0], rdat);
        end
        if (!rst)
            clr_seen <= clr_seen | clr;
        cycles++;
        if (cycles == 4000) begin
            err_total++;
            wrap_up();
        end
    end
    // ==========================
    // scenarios
    initial begin
        void'($urandom(35024));
        p = 10'($urandom) | 10'h001;
        rt = 10'($urandom);
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int a = 3; a <= 11; a++)
            if (a < 9 || a == 11) rd(4'(a), 8'h00);
        bus(4'h0, 1'b0, 8'h00, 34'h1_0000_0000);
        bus(4'hC, 1'b1, 8'hFF, 34'h1_0000_0000);
        src <= p;
        rd(`EFIC_ADDR_FLAGS_LOW, p[7:0]);
        rd(`EFIC_ADDR_FLAGS_HIGH, {6'h0, p[9:8]});
        chk_bit("line_a", 1'b1, line_a);
        chk_bit("line_b", 1'b1, line_b);
        other_n <= 1'b0;
        @(posedge clk);
        chk_bit("line_a_wired", 1'b0, line_a);
        other_n <= 1'b1;
        src <= 10'h000;
        wr(`EFIC_ADDR_ROUTE_LOW, rt[7:0]);
        wr(`EFIC_ADDR_ROUTE_HIGH, {6'h0, rt[9:8]});
        wr(`EFIC_ADDR_ENABLE_LOW, 8'hFF);
        wr(`EFIC_ADDR_ENABLE_HIGH, 8'h03);
        src <= p;
        @(posedge clk);
        src <= 10'h000;
        repeat (3) @(posedge clk);
        chk_bit("line_a", !(|(p & ~rt)), line_a);
        chk_bit("line_b", !(|(p & rt)), line_b);
        rd(`EFIC_ADDR_FLAGS_LOW, p[7:0]);
        rd(`EFIC_ADDR_FLAGS_HIGH, {6'h0, p[9:8]});
        wr(`EFIC_ADDR_FLAGS_LOW, p[7:0]);
        rd(`EFIC_ADDR_FLAGS_LOW, 8'h00);
        rd(`EFIC_ADDR_FLAGS_HIGH, {6'h0, p[9:8]});
        chk_word("source_clear", {22'h0, 2'b00, p[7:0]}, {22'h0, clr_seen});
        chk_bit("line_a", !(|(p[9:8] & ~rt[9:8])), line_a);
        chk_bit("line_b", !(|(p[9:8] & rt[9:8])), line_b);
        wr(`EFIC_ADDR_SOFT_RESET, 8'h01);
        rd(`EFIC_ADDR_FLAGS_HIGH, 8'h00);
        chk_bit("line_a", 1'b1, line_a);
        chk_bit("line_b", 1'b1, line_b);
        chk_bit("irq_masked", 1'b0, irq);
        wr(`EFIC_ADDR_MASK, 8'h03);
        rd(`EFIC_ADDR_MASK, 8'h03);
        chk_bit("irq", 1'b1, irq);
        rd(`EFIC_ADDR_STATUS, {6'h0, |(p & rt), |(p & ~rt)});
        chk_bit("irq", 1'b0, irq);
        rd(`EFIC_ADDR_STATUS, 8'h00);
        // host service routine on flag 0
        src <= 10'h001;
        @(posedge clk);
        src <= 10'h000;
        repeat (3) @(posedge clk);
        rd(`EFIC_ADDR_FLAGS_LOW, 8'h01);
        wr(`EFIC_ADDR_ENABLE_LOW, 8'hFE);
        rd(`EFIC_ADDR_FLAGS_LOW, 8'h00);
        wr(`EFIC_ADDR_FLAGS_LOW, 8'h01);
        wr(`EFIC_ADDR_ENABLE_LOW, 8'hFF);
        rd(`EFIC_ADDR_FLAGS_LOW, 8'h00);
        chk_bit("line_a", 1'b1, line_a);
        chk_bit("line_b", 1'b1, line_b);
        chk_bit("irq", 1'b1, irq);
        rd(`EFIC_ADDR_STATUS, {6'h0, rt[0], !rt[0]});
        // hardware reset in mid-run clears a latched flag
        src <= 10'h002;
        @(posedge clk);
        src <= 10'h000;
        repeat (3) @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk_bit("line_a_rst", 1'b1, line_a);
        chk_bit("line_b_rst", 1'b1, line_b);
        chk_bit("irq_rst", 1'b0, irq);
        rd(`EFIC_ADDR_ENABLE_LOW, 8'h00);
        wr(`EFIC_ADDR_ENABLE_LOW, 8'hFF);
        rd(`EFIC_ADDR_FLAGS_LOW, 8'h00);
        wrap_up();
    end
endmodule : efic_core_tb_top
